// *** src/ctw_pkg.sv ***
// Package for the transceiver mode and wake logic.
// Assumes a 100 MHz ref_clk; all times become cycle counts here.
package ctw_pkg;

   // ==========================================================
   // Clock and time base
   localparam int CLK_PERIOD_NS = 10;
   // Filter must pass a 2 us bit, so 1 us leaves margin
   localparam int WAKE_FILTER_NS = 1000;
   localparam int WAKE_WINDOW_NS = 1000000;
   // Least time: rounded up
   localparam int FILTER_CYC = (WAKE_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Longest time: rounded down
   localparam int WINDOW_CYC = WAKE_WINDOW_NS / CLK_PERIOD_NS;

   // ==========================================================
   // Counter widths
   localparam int RUN_W = 8;
   localparam int WIN_W = 20;

   // ==========================================================
   // Synchroniser pin positions and reset levels
   localparam int PIN_N = 3;
   localparam int PIN_TXD = 0;
   localparam int PIN_LPS = 1;
   localparam int PIN_BUSDOM = 2;
   // Transmit recessive, standby selected, bus not dominant
   localparam logic [2:0] PIN_RST = 3'h3;

   // ==========================================================
   // Event buffer
   localparam int EVT_W = 8;
   localparam int EVT_DEPTH = 8;

   // ==========================================================
   // Output reset values
   localparam logic RXD_RST = 1'h1;
   localparam logic STANDBY_RST = 1'h1;

   typedef enum logic [2:0] {
      WK_IDLE,
      WK_WAIT_REC,
      WK_WAIT_DOM2,
      WK_WOKE
   } ctw_wake_t;

endpackage

// *** src/ctw_fifo.sv ***
// Small synchronous FIFO carrying wake events to the receive output.
// Single clock; DEPTH must be a power of two.
module ctw_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   // Clock and control
   input  wire logic             clk,
   input  wire logic             rstN,
   input  wire logic             clkEn,
   input  wire logic             flush,
   // Fill side
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   // Drain side
   output logic                  outValid,
   input  wire logic             outReady,
   output logic [WIDTH-1:0]      outData
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wrPtr_r;
   logic [AW:0]      rdPtr_r;
   wire  [AW:0]      level = wrPtr_r - rdPtr_r;
   wire              push = inValid && inReady;
   wire              pop = outValid && outReady;

   assign inReady = (level != (AW + 1)'(DEPTH));
   assign outValid = (level != '0);
   assign outData = mem[rdPtr_r[AW-1:0]];

   always_ff @(posedge clk) begin
      if (clkEn && push) begin
         mem[wrPtr_r[AW-1:0]] <= inData;
      end
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         wrPtr_r <= '0;
         rdPtr_r <= '0;
      end else if (clkEn) begin
         if (flush) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
         end else begin
            if (push) wrPtr_r <= wrPtr_r + 1'b1;
            if (pop) rdPtr_r <= rdPtr_r + 1'b1;
         end
      end
   end
endmodule

// *** src/ctw_mode_wake.sv ***
// Mode control and remote wake logic of a high-speed CAN transceiver.
// Assumes busDomIn is the comparator output of the bus receiver
// (1 = differential voltage says dominant) and that pins are asynchronous.
// clkEn low freezes every flop; WINDOW_CYCLES must fit the window counter
// and FIFO_DEPTH must be a power of two.
//
// How it works
// - Select input high standby, low normal
// - Normal mode enables driver and main receiver
// - Transmit low drives dominant; receive mirrors bus
// - Standby: driver off, weak ground bias
// - Standby holds receive high until wake
// - Wake needs dominant, recessive, dominant, filtered
// - Unfiltered activity never resets pattern monitor
// - Wake shown as low pulse, filter long
// - Each later filtered dominant pulses receive low
// - Only states longer than filter time count
// - Filter passes 2 us bit in either state
// - Pattern timeout restarts monitor without wake
// - Low means dominant, high means recessive
// - Open select biases standby, open transmit recessive
module ctw_mode_wake
   import ctw_pkg::*;
#(
   parameter int WINDOW_CYCLES = WINDOW_CYC,
   parameter int FIFO_DEPTH    = EVT_DEPTH
) (
   // Clock, reset, enable
   input  wire logic ref_clk,
   input  wire logic rst_n,
   input  wire logic clkEn,
   // Host side pins
   input  wire logic txdIn,
   input  wire logic lowPowerSelectIn,
   output logic      rxdOut,
   // Bus side
   input  wire logic busDomIn,
   output logic      busDriveDomOut,
   output logic      driverEnOut,
   output logic      mainRxEnOut,
   output logic      lowPowerRxEnOut,
   output logic      busWeakGndOut,
   // Pin bias and status
   output logic      txdPullUpOut,
   output logic      lowPowerSelectPullUpOut,
   output logic      standbyOut,
   output logic      wakeSeenOut
);

   // ==========================================================
   // Reset release
   logic [1:0] rstSync_r;
   wire        rstInt_n = rstSync_r[1];

   // Release waits two edges so no flop leaves reset on its own edge
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rstSync_r <= 2'h0;
      end else if (clkEn) begin
         rstSync_r <= {rstSync_r[0], 1'b1};
      end
   end

   // ==========================================================
   // Pin synchronisers
   // Reset levels match the pin bias, so an open pin reads as after reset
   logic [PIN_N-1:0] pinMeta_r;
   logic [PIN_N-1:0] pinSync_r;
   wire  [PIN_N-1:0] pinRaw = {busDomIn, lowPowerSelectIn, txdIn};

   genvar gi;
   generate
      for (gi = 0; gi < PIN_N; gi++) begin : g_sync
         always_ff @(posedge ref_clk or negedge rstInt_n) begin
            if (!rstInt_n) begin
               pinMeta_r[gi] <= PIN_RST[gi];
               pinSync_r[gi] <= PIN_RST[gi];
            end else if (clkEn) begin
               pinMeta_r[gi] <= pinRaw[gi];
               pinSync_r[gi] <= pinMeta_r[gi];
            end
         end
      end
   endgenerate

   wire txdSync = pinSync_r[PIN_TXD];
   wire busDom = pinSync_r[PIN_BUSDOM];

   // ==========================================================
   // Mode decode
   // select level picks mode
   wire standbySel = pinSync_r[PIN_LPS];
   wire normalSel = !standbySel;
   logic standby_r;
   wire  enterNormal = standby_r && normalSel;
   // Monitor, buffer and pulse are cleared while standby_r is low, so any
   // visit to normal mode, however short, restarts the wake pattern.
   // normal mode clears monitor
   wire  monitorClr = !standby_r;

   always_ff @(posedge ref_clk or negedge rstInt_n) begin
      if (!rstInt_n) begin
         standby_r <= STANDBY_RST;
      end else if (clkEn) begin
         standby_r <= standbySel;
      end
   end

   // ==========================================================
   // Bus state run filter
   // Counts how long the bus has held its present state; a state is
   // filtered once it has lasted more than the filter time.
   logic             busPrev_r;
   logic [RUN_W-1:0] runCnt_r;
   localparam logic [RUN_W-1:0] FILT_HIT = RUN_W'(FILTER_CYC);

   wire busChanged = (busDom != busPrev_r);
   wire runHit = !busChanged && (runCnt_r == FILT_HIT);
   // 100 cycles is under one 2 us bit
   wire filtDom = runHit && busDom;
   wire filtRec = runHit && !busDom;
   wire runSat = (runCnt_r == '1);
   wire [RUN_W-1:0] runNxt = busChanged ? RUN_W'(1) :
                             runSat ? runCnt_r : runCnt_r + 1'b1;

   always_ff @(posedge ref_clk or negedge rstInt_n) begin
      if (!rstInt_n) begin
         busPrev_r <= 1'b0;
         runCnt_r  <= '0;
      end else if (clkEn) begin
         busPrev_r <= busDom;
         runCnt_r  <= runNxt;
      end
   end

   // ==========================================================
   // Wake pattern monitor
   ctw_wake_t        wkState_r;
   ctw_wake_t        wkState_nxt;
   logic [WIN_W-1:0] winCnt_r;
   localparam logic [WIN_W-1:0] WIN_LAST = WIN_W'(WINDOW_CYCLES);

   wire inWindow = (wkState_r == WK_WAIT_REC) || (wkState_r == WK_WAIT_DOM2);
   wire winExpired = inWindow && (winCnt_r >= WIN_LAST);
   wire [WIN_W-1:0] winNxt = (inWindow && standby_r) ? winCnt_r + 1'b1 : '0;
   // expiry wins over a late dominant
   wire dom2Hit = (wkState_r == WK_WAIT_DOM2) && !winExpired;
   wire wokeHit = (wkState_r == WK_WOKE);
   wire evtFire = standby_r && filtDom && (dom2Hit || wokeHit);

   always_comb begin
      wkState_nxt = wkState_r;
      case (wkState_r)
         WK_IDLE: begin
            if (filtDom) wkState_nxt = WK_WAIT_REC;
         end
         WK_WAIT_REC: begin
            if (winExpired) wkState_nxt = WK_IDLE;
            else if (filtRec) wkState_nxt = WK_WAIT_DOM2;
         end
         WK_WAIT_DOM2: begin
            if (winExpired) wkState_nxt = WK_IDLE;
            else if (filtDom) wkState_nxt = WK_WOKE;
         end
         WK_WOKE: begin
            // Left only by normal mode; the window no longer applies
            wkState_nxt = WK_WOKE;
         end
         default: begin
            wkState_nxt = WK_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge rstInt_n) begin
      if (!rstInt_n) begin
         wkState_r <= WK_IDLE;
      end else if (clkEn) begin
         wkState_r <= monitorClr ? WK_IDLE : wkState_nxt;
      end
   end

   always_ff @(posedge ref_clk or negedge rstInt_n) begin
      if (!rstInt_n) begin
         winCnt_r <= '0;
      end else if (clkEn) begin
         winCnt_r <= winNxt;
      end
   end

   // ==========================================================
   // Event hand-off into the buffer
   // A pending event waits until the buffer accepts it; a further event
   // while one is pending merges into it rather than being queued.
   logic evtPending_r;
   wire  fifoInReady;
   wire  evtValid = evtPending_r || evtFire;
   wire  evtTaken = evtValid && fifoInReady;

   always_ff @(posedge ref_clk or negedge rstInt_n) begin
      if (!rstInt_n) begin
         evtPending_r <= 1'b0;
      end else if (clkEn) begin
         if (monitorClr) evtPending_r <= 1'b0;
         else evtPending_r <= evtValid && !evtTaken;
      end
   end

   wire             fifoOutValid;
   wire             fifoOutReady;
   wire [EVT_W-1:0] fifoOutData;
   wire             fifoInValid = evtValid && standby_r;
   // Each event carries its own pulse length, so the pulse logic needs no
   // knowledge of the filter setting.
   wire [EVT_W-1:0] evtLen = EVT_W'(FILTER_CYC);

   ctw_fifo #(
      .WIDTH (EVT_W),
      .DEPTH (FIFO_DEPTH)
   ) u_evt_fifo (
      .clk      (ref_clk),
      .rstN     (rstInt_n),
      .clkEn    (clkEn),
      .flush    (monitorClr),
      .inValid  (fifoInValid),
      .inReady  (fifoInReady),
      .inData   (evtLen),
      .outValid (fifoOutValid),
      .outReady (fifoOutReady),
      .outData  (fifoOutData)
   );

   // ==========================================================
   // Wake pulse generator
   // Drains one event at a time; while a pulse is running it refuses the
   // next event so the buffer, not the output, absorbs bursts.
   logic [EVT_W-1:0] lowCnt_r;
   wire              pulseBusy = (lowCnt_r != '0);
   assign fifoOutReady = !pulseBusy && standby_r;
   wire              pulseLoad = fifoOutValid && fifoOutReady;

   always_ff @(posedge ref_clk or negedge rstInt_n) begin
      if (!rstInt_n) begin
         lowCnt_r <= '0;
      end else if (clkEn) begin
         if (monitorClr) lowCnt_r <= '0;
         else if (pulseLoad) lowCnt_r <= fifoOutData;
         else if (pulseBusy) lowCnt_r <= lowCnt_r - 1'b1;
      end
   end

   // ==========================================================
   // Output next values
   // low is dominant on pins
   wire rxdNormal = !busDom;
   wire rxdStandby = !(pulseLoad || (pulseBusy && lowCnt_r != EVT_W'(1)));
   wire rxdNxt = normalSel ? rxdNormal : rxdStandby;
   wire driveNxt = normalSel && !txdSync;
   wire driverEnNxt = normalSel;
   wire mainRxEnNxt = normalSel;
   wire lowPowerRxEnNxt = standbySel;
   wire busWeakGndNxt   = standbySel;
   // host clears this by selecting normal
   wire wakeSeenNxt = standbySel && (wkState_nxt == WK_WOKE) && !enterNormal;

   // ==========================================================
   // Receive output
   // Mode outputs all take the synced select, so they switch on one edge
   always_ff @(posedge ref_clk or negedge rstInt_n) begin
      if (!rstInt_n) begin
         rxdOut <= RXD_RST;
      end else if (clkEn) begin
         rxdOut <= rxdNxt;
      end
   end

   // ==========================================================
   // Mode status
   always_ff @(posedge ref_clk or negedge rstInt_n) begin
      if (!rstInt_n) begin
         standbyOut  <= STANDBY_RST;
         wakeSeenOut <= 1'b0;
      end else if (clkEn) begin
         standbyOut  <= standbySel;
         wakeSeenOut <= wakeSeenNxt;
      end
   end

   // ==========================================================
   // Driver outputs
   always_ff @(posedge ref_clk or negedge rstInt_n) begin
      if (!rstInt_n) begin
         busDriveDomOut <= 1'b0;
         driverEnOut    <= 1'b0;
      end else if (clkEn) begin
         busDriveDomOut <= driveNxt;
         driverEnOut    <= driverEnNxt;
      end
   end

   // ==========================================================
   // Receiver enables and bus bias
   always_ff @(posedge ref_clk or negedge rstInt_n) begin
      if (!rstInt_n) begin
         mainRxEnOut     <= 1'b0;
         lowPowerRxEnOut <= 1'b1;
         busWeakGndOut   <= 1'b1;
      end else if (clkEn) begin
         mainRxEnOut     <= mainRxEnNxt;
         lowPowerRxEnOut <= lowPowerRxEnNxt;
         busWeakGndOut   <= busWeakGndNxt;
      end
   end

   // ==========================================================
   // Pin bias outputs
   // pins keep weak pull-ups
   // Held in both modes: an open pin must still read recessive and standby
   always_ff @(posedge ref_clk or negedge rstInt_n) begin
      if (!rstInt_n) begin
         txdPullUpOut            <= 1'b1;
         lowPowerSelectPullUpOut <= 1'b1;
      end else if (clkEn) begin
         txdPullUpOut            <= 1'b1;
         lowPowerSelectPullUpOut <= 1'b1;
      end
   end
endmodule

// *** tb/ctw_host_model.sv ***
// Host controller model: drives transmit and select pins.
// Assumes it shares ref_clk with the transceiver logic.
module ctw_host_model (
   // Clock and commands
   input  wire logic ref_clk,
   input  wire logic wantStandby,
   input  wire logic autoWake,
   input  wire logic txBit,
   // Transceiver pins
   input  wire logic rxdOut,
   output logic      txdIn,
   output logic      lowPowerSelectIn
);
   timeunit 1ns;
   timeprecision 1ps;
   logic woke_r = 1'b0;
   logic rxdPrev_r = 1'b1;

   // ==========================================
   // Pin drive
   // low is dominant
   assign txdIn = txBit;
   assign lowPowerSelectIn = wantStandby & ~woke_r;
   always @(posedge ref_clk) begin
      rxdPrev_r <= rxdOut;
      if (!wantStandby) woke_r <= 1'b0;
      else if (autoWake && rxdPrev_r && !rxdOut) woke_r <= 1'b1;
   end
endmodule

// *** tb/ctw_mode_wake_sva.sv ***
// Checker for the mode and wake logic, bound to its top.
// Assumes a three-edge pin latency and the package filter count.
module ctw_mode_wake_sva
   import ctw_pkg::*;
#(
   parameter int WINDOW_CYCLES = WINDOW_CYC,
   parameter int FIFO_DEPTH    = EVT_DEPTH
) (
   // Clock and pins
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic clkEn,
   input wire logic txdIn,
   input wire logic lowPowerSelectIn,
   input wire logic rxdOut,
   input wire logic busDomIn,
   // Bus control and status
   input wire logic busDriveDomOut,
   input wire logic driverEnOut,
   input wire logic mainRxEnOut,
   input wire logic lowPowerRxEnOut,
   input wire logic busWeakGndOut,
   input wire logic txdPullUpOut,
   input wire logic lowPowerSelectPullUpOut,
   input wire logic standbyOut,
   input wire logic wakeSeenOut
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] upCnt_r;
   logic [7:0] lowLen_r;
   logic       ready;

   // ==========================================
   // Helpers
   // Pin latency only holds once reset and synchronisers drained
   assign ready = (upCnt_r == 3'h7);
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         upCnt_r  <= 3'h0;
         lowLen_r <= 8'h0;
      end else if (!clkEn) begin
         // Frozen pipeline breaks the pin latency; wait for it to refill
         upCnt_r  <= 3'h0;
      end else begin
         upCnt_r  <= upCnt_r + {2'h0, !ready};
         lowLen_r <= rxdOut ? 8'h0 : lowLen_r + 8'h1;
      end
   end
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n || !clkEn);

   // ==========================================
   // Properties
   sequence s_wakeHit; $rose(wakeSeenOut); endsequence
   sequence s_pulseGo; ##[0:3] !rxdOut; endsequence
   property p_mode; ready |-> standbyOut == $past(lowPowerSelectIn, 3); endproperty
   property p_txd;
      ready && !$past(lowPowerSelectIn, 3) |-> busDriveDomOut == !$past(txdIn, 3);
   endproperty
   property p_rxNorm;
      ready && !$past(lowPowerSelectIn, 3) |-> rxdOut == !$past(busDomIn, 3);
   endproperty
   property p_normEn;
      !standbyOut |-> driverEnOut && mainRxEnOut && !lowPowerRxEnOut && !busWeakGndOut;
   endproperty
   property p_stbyEn;
      standbyOut |-> !driverEnOut && !mainRxEnOut && !busDriveDomOut
         && lowPowerRxEnOut && busWeakGndOut;
   endproperty
   property p_stbyRxd; standbyOut && !wakeSeenOut |-> rxdOut; endproperty
   property p_pulse;
      standbyOut && $past(standbyOut) && $rose(rxdOut) |-> lowLen_r == FILTER_CYC;
   endproperty
   property p_wake; s_wakeHit |-> s_pulseGo; endproperty
   a_mode: assert property (p_mode) else $error("mode wrong");
   a_txd: assert property (p_txd) else $error("drive wrong");
   a_rxNorm: assert property (p_rxNorm) else $error("receive wrong");
   a_normEn: assert property (p_normEn) else $error("normal enables");
   a_stbyEn: assert property (p_stbyEn) else $error("standby enables");
   a_stbyRxd: assert property (p_stbyRxd) else $error("receive not high");
   a_pulse: assert property (p_pulse) else $error("pulse length");
   a_wake: assert property (p_wake) else $error("no wake edge");
endmodule

bind ctw_mode_wake ctw_mode_wake_sva #(.WINDOW_CYCLES(WINDOW_CYCLES), .FIFO_DEPTH(FIFO_DEPTH))
   ctw_mode_wake_sva_inst (.*);

// *** tb/tb_top.sv ***
// Self-checking bench for the mode and wake logic.
// Assumes the host model owns the select and transmit pins.
module tb_top
   import ctw_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   // Short window keeps the timeout case quick
   localparam int WIN = 2000;
   // Select, transmit, bus | drive, receive, standby
   localparam logic [5:0] ROWS [5] = '{6'h0c, 6'h12, 6'h06, 6'h2b, 6'h18};
   logic ref_clk, rst_n, clkEn, busDomIn, wantStandby, autoWake, txBit, txdIn;
   logic lowPowerSelectIn, rxdOut, busDriveDomOut, driverEnOut, mainRxEnOut;
   logic lowPowerRxEnOut, busWeakGndOut, txdPullUpOut, lowPowerSelectPullUpOut;
   logic standbyOut, wakeSeenOut;
   logic rxdPrev = 1'b1;
   int   fails, cmp_count, base;
   int   falls = 0;

   ctw_mode_wake #(.WINDOW_CYCLES(WIN)) ctw_mode_wake_inst (.*);
   ctw_host_model ctw_host_model_inst (.*);

   // ==========================================
   // Clock and wake edge count
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      if (standbyOut === 1'b1 && rxdPrev === 1'b1 && rxdOut === 1'b0) falls <= falls + 1;
      rxdPrev <= rxdOut;
   end

   // ==========================================
   // Tasks
   task automatic chk(input logic got, input logic exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: got %b, expected %b", $time, got, exp);
      end
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge ref_clk);
      @(negedge ref_clk);
   endtask
   // Bus phases alternate, dominant first
   task automatic run(input int lens[]);
      foreach (lens[j]) begin
         @(posedge ref_clk);
         busDomIn <= !j[0];
         repeat (lens[j] - 1) @(posedge ref_clk);
      end
      settle(1);
   endtask
   task automatic mode(input logic stby);
      @(posedge ref_clk);
      wantStandby <= stby;
      autoWake <= 1'b0;
      busDomIn <= 1'b0;
      settle(20);
   endtask
   task automatic final_report;
      $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // ==========================================
   // Main sequence
   initial begin
      rst_n = 1'b0;
      clkEn = 1'b1;
      busDomIn = 1'b0;
      wantStandby = 1'b0;
      autoWake = 1'b0;
      txBit = 1'b1;
      fails = 0;
      cmp_count = 0;
      settle(9);
      chk(standbyOut & rxdOut, 1'b1);
      chk(txdPullUpOut & lowPowerSelectPullUpOut, 1'b1);
      @(posedge ref_clk);
      rst_n <= 1'b1;
      settle(8);
      chk(standbyOut, 1'b0);
      foreach (ROWS[k]) begin
         @(posedge ref_clk);
         {wantStandby, txBit, busDomIn} <= ROWS[k][5:3];
         settle(5);
         chk(busDriveDomOut, ROWS[k][2]);
         chk(rxdOut, ROWS[k][1]);
         chk(driverEnOut, !ROWS[k][0]);
         chk(standbyOut, ROWS[k][0]);
         chk(mainRxEnOut, !ROWS[k][0]);
         chk(lowPowerRxEnOut & busWeakGndOut, ROWS[k][0]);
      end
      // Frozen clock enable holds the mode through a select change
      @(posedge ref_clk);
      clkEn <= 1'b0;
      wantStandby <= 1'b1;
      settle(10);
      chk(standbyOut, 1'b0);
      @(posedge ref_clk);
      clkEn <= 1'b1;
      settle(5);
      chk(standbyOut, 1'b1);
      mode(1'b1);
      base = falls;
      // Short phases neither start nor reset the pattern
      run('{FILTER_CYC - 10, 200, 200, 50, 50, 200, 50, 50});
      chk(falls == base, 1'b1);
      run('{200, 200});
      chk(falls == base + 1, 1'b1);
      chk(wakeSeenOut, 1'b1);
      run('{200, 200});
      chk(falls == base + 2, 1'b1);
      @(posedge ref_clk);
      autoWake <= 1'b1;
      run('{200, 200});
      chk(standbyOut | wakeSeenOut, 1'b0);
      mode(1'b0);
      mode(1'b1);
      base = falls;
      run('{200, WIN + 500, 200, 200});
      chk(falls == base, 1'b1);
      run('{200, 200});
      chk(falls == base + 1, 1'b1);
      // Reset in mid-run drops the wake state and returns to standby
      @(posedge ref_clk);
      rst_n <= 1'b0;
      settle(2);
      chk(standbyOut & rxdOut & !wakeSeenOut, 1'b1);
      @(posedge ref_clk);
      rst_n <= 1'b1;
      settle(8);
      chk(standbyOut & !driverEnOut, 1'b1);
      final_report();
   end
endmodule
